// ### hdl/spl_port_ctrl.sv
// Switch port link control: negotiation, duplex, flow control, crossover, loopback
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
module spl_port_ctrl #(
  parameter int NEG_WAIT = spl_pkg::NEG_WAIT_CYC,
  parameter int DW       = 8
) (
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // Cable side pins (asynchronous)
  input  wire logic          line_signal,
  input  wire logic [1:0]    line_speed,
  input  wire logic          peer_neg_valid,
  input  wire logic [4:0]    peer_ability,
  input  wire logic          line_rx_active,
  input  wire logic          alt_pair_energy,
  // Cable side outputs
  output logic [4:0]         local_ability,
  output logic               auto_cable_crossover,
  output logic               phy_tx_en,
  output logic [DW-1:0]      phy_txd,
  output logic               phy_jam,
  output logic               phy_pause,
  // PHY receive data, already on hclk
  input  wire logic          phy_rx_dv,
  input  wire logic [DW-1:0] phy_rxd,
  // MAC side
  input  wire logic          mac_tx_req,
  input  wire logic [DW-1:0] mac_txd,
  input  wire logic          rx_buf_full,
  output logic               mac_tx_grant,
  output logic               mac_rx_dv,
  output logic [DW-1:0]      mac_rxd,
  // Resolved link state
  output logic               link_up,
  output logic [1:0]         link_speed,
  output logic               link_full
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  localparam int SW = 11;
  logic [SW-1:0] pins_s;
  logic          sig_s;
  logic [1:0]    spd_s;
  logic          negv_s;
  logic [4:0]    pabil_s;
  logic          rxact_s;
  logic          alt_s;

  spl_sync #(.W(SW)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .async_i ({line_signal, line_speed, peer_neg_valid, peer_ability, line_rx_active, alt_pair_energy}),
    .sync_o  (pins_s)
  );

  assign {sig_s, spd_s, negv_s, pabil_s, rxact_s, alt_s} = pins_s;

  // ------------------------------------------------------------------
  // AHB-Lite slave and registers
  // ------------------------------------------------------------------
  logic [3:0]  mode_q;
  logic        flow_en_q;
  logic        loop_q;
  logic        shut_q;
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic        acc;
  logic        wr_ctrl;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;

  assign acc     = hsel && hready && htrans[1];
  assign wr_ctrl = wr_pend_q && (wr_addr_q == spl_pkg::ADDR_CTRL);

  // Address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else if (hready) begin
      wr_pend_q <= acc && hwrite;
      wr_addr_q <= haddr[spl_pkg::ADDR_W-1:0];
    end
  end

  // Control register, written in the data phase
  // defaults after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q    <= spl_pkg::MODE_AUTO;
      flow_en_q <= 1'b1;
      loop_q    <= 1'b0;
      shut_q    <= 1'b0;
    end else if (wr_ctrl) begin
      mode_q    <= hwdata[spl_pkg::CTRL_MODE_LSB +: spl_pkg::CTRL_MODE_W];
      flow_en_q <= hwdata[spl_pkg::CTRL_FLOW_BIT];
      loop_q    <= hwdata[spl_pkg::CTRL_LOOP_BIT];
      shut_q    <= hwdata[spl_pkg::CTRL_SHUT_BIT];
    end
  end

  // Read views; a write in its data phase is forwarded to a read behind it
  always_comb begin
    ctrl_rd = '0;
    if (wr_ctrl) begin
      ctrl_rd[spl_pkg::CTRL_SHUT_BIT:0] = hwdata[spl_pkg::CTRL_SHUT_BIT:0];
    end else begin
      ctrl_rd[spl_pkg::CTRL_MODE_LSB +: spl_pkg::CTRL_MODE_W] = mode_q;
      ctrl_rd[spl_pkg::CTRL_FLOW_BIT] = flow_en_q;
      ctrl_rd[spl_pkg::CTRL_LOOP_BIT] = loop_q;
      ctrl_rd[spl_pkg::CTRL_SHUT_BIT] = shut_q;
    end
  end

  spl_pkg::spl_state_e st_q;
  logic        peer_neg_q;
  logic [31:0] cnt_q;

  always_comb begin
    stat_rd = '0;
    stat_rd[spl_pkg::STAT_LINK_BIT]       = link_up;
    stat_rd[spl_pkg::STAT_SPD_LSB +: 2]   = link_speed;
    stat_rd[spl_pkg::STAT_FULL_BIT]       = link_full;
    stat_rd[spl_pkg::STAT_XOVER_BIT]      = auto_cable_crossover;
    stat_rd[spl_pkg::STAT_PAUSE_BIT]      = phy_pause;
    stat_rd[spl_pkg::STAT_BP_BIT]         = phy_jam;
    stat_rd[spl_pkg::STAT_NEG_BIT]        = peer_neg_q;
  end

  // Read data and response; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc && !hwrite) begin
        unique case (haddr[spl_pkg::ADDR_W-1:0])
          spl_pkg::ADDR_CTRL:   hrdata <= ctrl_rd;
          spl_pkg::ADDR_STATUS: hrdata <= stat_rd;
          default:              hrdata <= '0;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  logic       mode_neg;
  logic [4:0] mode_abil;
  logic [1:0] force_spd;
  logic       force_full;

  // Abilities advertised and forced settings per mode
  // gigabit setting always negotiates
  always_comb begin
    mode_neg   = 1'b1;
    mode_abil  = spl_pkg::ABIL_ALL;
    force_spd  = spl_pkg::SPD_10;
    force_full = 1'b0;
    unique case (mode_q)
      spl_pkg::MODE_10_FULL:     begin mode_neg = 1'b0; force_full = 1'b1; end
      spl_pkg::MODE_10_FULL_N:   mode_abil = 5'h01 << spl_pkg::ABIL_10F;
      spl_pkg::MODE_10_HALF:     mode_neg = 1'b0;
      spl_pkg::MODE_10_HALF_N:   mode_abil = 5'h01 << spl_pkg::ABIL_10H;
      spl_pkg::MODE_100_FULL: begin
        mode_neg   = 1'b0;
        force_spd  = spl_pkg::SPD_100;
        force_full = 1'b1;
      end
      spl_pkg::MODE_100_FULL_N:  mode_abil = 5'h01 << spl_pkg::ABIL_100F;
      spl_pkg::MODE_100_HALF: begin
        mode_neg  = 1'b0;
        force_spd = spl_pkg::SPD_100;
      end
      spl_pkg::MODE_100_HALF_N:  mode_abil = 5'h01 << spl_pkg::ABIL_100H;
      spl_pkg::MODE_1000_FULL,
      spl_pkg::MODE_1000_FULL_N: mode_abil = 5'h01 << spl_pkg::ABIL_1000F;
      default:                   mode_abil = spl_pkg::ABIL_ALL;
    endcase
  end

  // Highest common ability
  // priority resolution
  logic [4:0] common;
  logic       common_ok;
  logic [1:0] res_spd;
  logic       res_full;

  assign common    = mode_abil & pabil_s;
  assign common_ok = |common;

  always_comb begin
    res_spd  = spl_pkg::SPD_10;
    res_full = 1'b0;
    if (common[spl_pkg::ABIL_1000F]) begin
      res_spd  = spl_pkg::SPD_1000;
      res_full = 1'b1;
    end else if (common[spl_pkg::ABIL_100F]) begin
      res_spd  = spl_pkg::SPD_100;
      res_full = 1'b1;
    end else if (common[spl_pkg::ABIL_100H]) begin
      res_spd  = spl_pkg::SPD_100;
    end else if (common[spl_pkg::ABIL_10F]) begin
      res_full = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Link state machine
  // ------------------------------------------------------------------
  // shutdown takes the port down from any state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q       <= spl_pkg::ST_OFF;
      cnt_q      <= '0;
      link_up    <= 1'b0;
      link_speed <= spl_pkg::SPD_10;
      link_full  <= 1'b0;
      peer_neg_q <= 1'b0;
    end else if (shut_q) begin
      st_q    <= spl_pkg::ST_OFF;
      link_up <= 1'b0;
    end else begin
      unique case (st_q)
        spl_pkg::ST_OFF: st_q <= spl_pkg::ST_IDLE;
        spl_pkg::ST_IDLE: begin
          cnt_q   <= '0;
          if (sig_s && mode_neg) begin
            st_q <= spl_pkg::ST_NEG;
          end else if (sig_s) begin
            st_q       <= spl_pkg::ST_UP;
            link_up    <= 1'b1;
            link_speed <= force_spd;
            link_full  <= force_full;
            peer_neg_q <= 1'b0;
          end
        end
        spl_pkg::ST_NEG: begin
          cnt_q <= cnt_q + 32'h00000001;
          if (!sig_s) begin
            st_q <= spl_pkg::ST_IDLE;
          end else if (negv_s) begin
            if (common_ok) begin
              st_q       <= spl_pkg::ST_UP;
              link_up    <= 1'b1;
              link_speed <= res_spd;
              link_full  <= res_full;
              peer_neg_q <= 1'b1;
            end
          end else if (cnt_q >= 32'(NEG_WAIT - 1) && spd_s != spl_pkg::SPD_1000) begin
            // a gigabit line never comes up unnegotiated
            st_q       <= spl_pkg::ST_UP;
            link_up    <= 1'b1;
            link_speed <= spd_s;
            link_full  <= 1'b0;
            peer_neg_q <= 1'b0;
          end
        end
        spl_pkg::ST_UP: begin
          if (!sig_s) begin
            st_q    <= spl_pkg::ST_IDLE;
            link_up <= 1'b0;
          end
        end
      endcase
    end
  end

  // Advertised abilities; nothing while shut down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      local_ability <= '0;
    end else begin
      local_ability <= (shut_q || !mode_neg) ? 5'h00 : mode_abil;
    end
  end

  // ------------------------------------------------------------------
  // Automatic crossover
  // ------------------------------------------------------------------
  // only in fully automatic mode
  // follow pair energy while no link
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auto_cable_crossover <= 1'b0;
    end else if (mode_q != spl_pkg::MODE_AUTO) begin
      auto_cable_crossover <= 1'b0;
    end else if (st_q != spl_pkg::ST_UP) begin
      auto_cable_crossover <= alt_s;
    end
  end

  // ------------------------------------------------------------------
  // Flow control
  // ------------------------------------------------------------------
  // gated by the on/off setting
  // kind follows duplex latched at link up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_pause <= 1'b0;
      phy_jam   <= 1'b0;
    end else begin
      phy_pause <= flow_en_q && link_up && link_full && rx_buf_full;
      phy_jam   <= flow_en_q && link_up && !link_full && rx_buf_full && rxact_s;
    end
  end

  // ------------------------------------------------------------------
  // Data paths and loopback
  // ------------------------------------------------------------------
  logic tx_ok;

  assign tx_ok = mac_tx_req && (loop_q || (link_up && (link_full || !rxact_s && !phy_jam)));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mac_tx_grant <= 1'b0;
      phy_tx_en    <= 1'b0;
      phy_txd      <= '0;
      mac_rx_dv    <= 1'b0;
      mac_rxd      <= '0;
    end else begin
      mac_tx_grant <= tx_ok && !shut_q;
      phy_tx_en    <= tx_ok && !shut_q && !loop_q;
      phy_txd      <= loop_q ? '0 : mac_txd;
      if (loop_q) begin
        mac_rx_dv <= tx_ok && !shut_q;
        mac_rxd   <= mac_txd;
      end else begin
        mac_rx_dv <= phy_rx_dv && link_up && !shut_q;
        mac_rxd   <= phy_rxd;
      end
    end
  end

endmodule

// ### hdl/spl_pkg.sv
// Shared constants for the switch port link control block
package spl_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam int          ADDR_W      = 12;

  // Control register fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_MODE_W    = 4;
  localparam int CTRL_FLOW_BIT  = 4;
  localparam int CTRL_LOOP_BIT  = 5;
  localparam int CTRL_SHUT_BIT  = 6;

  // Status register fields
  localparam int STAT_LINK_BIT  = 0;
  localparam int STAT_SPD_LSB   = 1;
  localparam int STAT_FULL_BIT  = 3;
  localparam int STAT_XOVER_BIT = 4;
  localparam int STAT_PAUSE_BIT = 5;
  localparam int STAT_BP_BIT    = 6;
  localparam int STAT_NEG_BIT   = 7;

  // ------------------------------------------------------------------
  // Speed and duplex modes
  // ------------------------------------------------------------------
  localparam logic [3:0] MODE_AUTO       = 4'h0;
  localparam logic [3:0] MODE_10_FULL    = 4'h1;
  localparam logic [3:0] MODE_10_FULL_N  = 4'h2;
  localparam logic [3:0] MODE_10_HALF    = 4'h3;
  localparam logic [3:0] MODE_10_HALF_N  = 4'h4;
  localparam logic [3:0] MODE_100_FULL   = 4'h5;
  localparam logic [3:0] MODE_100_FULL_N = 4'h6;
  localparam logic [3:0] MODE_100_HALF   = 4'h7;
  localparam logic [3:0] MODE_100_HALF_N = 4'h8;
  localparam logic [3:0] MODE_1000_FULL  = 4'h9;
  localparam logic [3:0] MODE_1000_FULL_N = 4'hA;

  // Speed codes
  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // Ability bit positions
  localparam int ABIL_W     = 5;
  localparam int ABIL_10H   = 0;
  localparam int ABIL_10F   = 1;
  localparam int ABIL_100H  = 2;
  localparam int ABIL_100F  = 3;
  localparam int ABIL_1000F = 4;
  localparam logic [4:0] ABIL_ALL = 5'h1F;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ       = 10_000_000;
  localparam int NEG_WAIT_MS  = 50;
  localparam int NEG_WAIT_CYC = NEG_WAIT_MS * (CLK_HZ / 1000);

  // Link states
  typedef enum logic [1:0] {
    ST_OFF,
    ST_IDLE,
    ST_NEG,
    ST_UP
  } spl_state_e;

endpackage

// ### hdl/spl_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels
module spl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // Two flops in a row; only the second is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ### test/spl_peer.sv
// Peer port model across the cable
module spl_peer (
  // Clock
  input  wire logic       hclk,
  // Scenario controls
  input  wire logic       c_on,
  input  wire logic       c_neg,
  input  wire logic       c_busy,
  input  wire logic       c_cross,
  input  wire logic [1:0] c_spd,
  input  wire logic [4:0] c_abil,
  // Cable side
  output logic            line_signal,
  output logic [1:0]      line_speed,
  output logic            peer_neg_valid,
  output logic [4:0]      peer_ability,
  output logic            line_rx_active,
  output logic            alt_pair_energy,
  output logic            phy_rx_dv,
  output logic [7:0]      phy_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] count_q = 8'h00;

  // Receive bytes change every cycle, so stale data never looks valid
  always_ff @(posedge hclk) begin
    count_q <= count_q + 8'h01;
  end

  assign line_signal     = c_on;
  assign line_speed      = c_on ? c_spd : ~c_spd; // Released line inverts
  assign peer_neg_valid  = c_on & c_neg;
  assign peer_ability    = c_neg ? c_abil : ~c_abil;
  assign line_rx_active  = c_on & c_busy;
  assign alt_pair_energy = c_on & c_cross;
  assign phy_rx_dv       = c_busy;
  assign phy_rxd         = count_q;
endmodule

// ### test/spl_port_monitor.sv
// Assertion checker on the port control outputs
module spl_port_monitor (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Watched ports
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       mac_tx_req,
  input wire logic       rx_buf_full,
  input wire logic       mac_tx_grant,
  input wire logic       mac_rx_dv,
  input wire logic       phy_tx_en,
  input wire logic       phy_pause,
  input wire logic       phy_jam,
  input wire logic       link_up,
  input wire logic [1:0] link_speed,
  input wire logic       link_full
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Grant seen without a transmit to the line
  sequence s_loop_echo;
    mac_tx_grant && !phy_tx_en;
  endsequence
  // Transmit while the link was half duplex
  sequence s_half_tx;
    phy_tx_en && $past(link_up) && !$past(link_full);
  endsequence

  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  half_tx_hold_a: assert property (s_half_tx |-> !$past(phy_jam))
    else $error("transmit launched while jamming");
  pause_cause_a: assert property (phy_pause |-> $past(link_up && link_full && rx_buf_full))
    else $error("pause without full duplex congestion");
  jam_cause_a: assert property (phy_jam |-> $past(link_up && !link_full && rx_buf_full))
    else $error("jam without half duplex congestion");
  flow_excl_a: assert property (!(phy_pause && phy_jam))
    else $error("pause and jam together");
  grant_req_a: assert property (mac_tx_grant |-> $past(mac_tx_req))
    else $error("grant without request");
  loop_echo_a: assert property (s_loop_echo |-> mac_rx_dv)
    else $error("grant went nowhere");
  link_hold_a: assert property (link_up && $past(link_up) |-> $stable(link_speed) && $stable(link_full))
    else $error("resolved link changed while up");
  gig_full_a: assert property (link_up && link_speed == spl_pkg::SPD_1000 |-> link_full)
    else $error("gigabit link not full duplex");
endmodule

bind spl_port_ctrl spl_port_monitor i_mon (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .mac_tx_req(mac_tx_req), .rx_buf_full(rx_buf_full), .mac_tx_grant(mac_tx_grant),
  .mac_rx_dv(mac_rx_dv), .phy_tx_en(phy_tx_en), .phy_pause(phy_pause), .phy_jam(phy_jam),
  .link_up(link_up), .link_speed(link_speed), .link_full(link_full));

// ### test/testbench.sv
// Self-checking testbench for the switch port link control
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, line_speed, link_speed, c_spd;
  logic [2:0]  hsize;
  logic        line_signal, peer_neg_valid, line_rx_active, alt_pair_energy, phy_rx_dv;
  logic [4:0]  peer_ability, local_ability, c_abil;
  logic        auto_cable_crossover, phy_tx_en, phy_jam, phy_pause, mac_tx_req, rx_buf_full;
  logic        mac_tx_grant, mac_rx_dv, link_up, link_full, c_on, c_neg, c_busy, c_cross;
  logic [7:0]  phy_txd, phy_rxd, mac_txd, mac_rxd;
  int          n_errors, num_checks;

  spl_port_ctrl #(.NEG_WAIT(20), .DW(8)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .line_signal(line_signal), .line_speed(line_speed), .peer_neg_valid(peer_neg_valid),
    .peer_ability(peer_ability), .line_rx_active(line_rx_active), .alt_pair_energy(alt_pair_energy),
    .local_ability(local_ability), .auto_cable_crossover(auto_cable_crossover),
    .phy_tx_en(phy_tx_en), .phy_txd(phy_txd), .phy_jam(phy_jam), .phy_pause(phy_pause),
    .phy_rx_dv(phy_rx_dv), .phy_rxd(phy_rxd), .mac_tx_req(mac_tx_req), .mac_txd(mac_txd),
    .rx_buf_full(rx_buf_full), .mac_tx_grant(mac_tx_grant), .mac_rx_dv(mac_rx_dv),
    .mac_rxd(mac_rxd), .link_up(link_up), .link_speed(link_speed), .link_full(link_full));

  spl_peer i_peer (.hclk(hclk), .c_on(c_on), .c_neg(c_neg), .c_busy(c_busy), .c_cross(c_cross),
    .c_spd(c_spd), .c_abil(c_abil), .line_signal(line_signal), .line_speed(line_speed),
    .peer_neg_valid(peer_neg_valid), .peer_ability(peer_ability), .line_rx_active(line_rx_active),
    .alt_pair_energy(alt_pair_energy), .phy_rx_dv(phy_rx_dv), .phy_rxd(phy_rxd));

  // Bus clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic complete_run;
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic fail_out;
    $display("ERROR at %0t: wait ran out", $time);
    n_errors++;
    complete_run;
  endtask

  // Single word transfer: address phase, then data phase
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int k;
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {20'h00000, a}; hwrite <= w; htrans <= 2'h2;
    k = 0;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
    rd = hrdata;
    if (k >= 50) fail_out;
  endtask

  task automatic wait_link(input logic v);
    for (int k = 0; k < 300 && link_up !== v; k++) @(negedge hclk);
    if (link_up !== v) fail_out;
  endtask

  task automatic peer(input logic on, input logic neg, input logic [1:0] spd, input logic [4:0] ab);
    @(posedge hclk);
    c_on <= on; c_neg <= neg; c_spd <= spd; c_abil <= ab;
    wait_link(on);
  endtask

  task automatic t_defaults;
    bus(spl_pkg::ADDR_CTRL, 1'b0, 32'h0); check(rd, 32'h10);
    bus(12'h008, 1'b1, 32'hFF); bus(12'h008, 1'b0, 32'h0); check(rd, 32'h0);
    bus(spl_pkg::ADDR_STATUS, 1'b1, 32'hFF); bus(spl_pkg::ADDR_STATUS, 1'b0, 32'h0); check(rd, 32'h0);
  endtask

  task automatic t_autoneg;
    c_cross <= 1'b1;
    peer(1'b1, 1'b1, spl_pkg::SPD_1000, 5'h0C);
    check({link_speed, link_full}, {spl_pkg::SPD_100, 1'b1});
    check(auto_cable_crossover, 1'b1);
    bus(spl_pkg::ADDR_STATUS, 1'b0, 32'h0); check(rd, 32'h9B);
  endtask

  task automatic t_full_flow;
    @(posedge hclk);
    c_busy <= 1'b1; mac_tx_req <= 1'b1; mac_txd <= 8'h5A; rx_buf_full <= 1'b1;
    repeat (5) @(negedge hclk);
    check({phy_tx_en, mac_tx_grant, mac_rx_dv, phy_txd}, {3'h7, 8'h5A});
    check({phy_pause, phy_jam}, 2'h2);
    check(mac_rxd, 8'(phy_rxd - 8'h01));
    bus(spl_pkg::ADDR_CTRL, 1'b1, 32'h0);
    repeat (2) @(negedge hclk);
    check(phy_pause, 1'b0);
    bus(spl_pkg::ADDR_CTRL, 1'b1, 32'h10);
    c_busy <= 1'b0; mac_tx_req <= 1'b0; rx_buf_full <= 1'b0;
  endtask

  task automatic t_half;
    peer(1'b0, 1'b0, spl_pkg::SPD_100, 5'h0);
    peer(1'b1, 1'b0, spl_pkg::SPD_100, 5'h0);
    check({link_speed, link_full}, {spl_pkg::SPD_100, 1'b0});
    @(posedge hclk);
    c_busy <= 1'b1; mac_tx_req <= 1'b1; rx_buf_full <= 1'b1;
    repeat (5) @(negedge hclk);
    check({phy_tx_en, mac_tx_grant}, 2'h0);
    check({phy_jam, phy_pause}, 2'h2);
    @(posedge hclk);
    c_busy <= 1'b0; rx_buf_full <= 1'b0;
    repeat (5) @(negedge hclk);
    check(phy_tx_en, 1'b1);
    @(posedge hclk);
    mac_tx_req <= 1'b0;
  endtask

  task automatic t_forced;
    peer(1'b0, 1'b0, spl_pkg::SPD_100, 5'h0);
    @(posedge hclk);
    c_on <= 1'b1; c_spd <= spl_pkg::SPD_1000;
    repeat (40) @(negedge hclk);
    check(link_up, 1'b0);
    peer(1'b0, 1'b0, spl_pkg::SPD_100, 5'h0);
    bus(spl_pkg::ADDR_CTRL, 1'b1, 32'h15);
    peer(1'b1, 1'b0, spl_pkg::SPD_100, 5'h0);
    check({link_speed, link_full}, {spl_pkg::SPD_100, 1'b1});
    check({local_ability, auto_cable_crossover}, 6'h0);
    peer(1'b0, 1'b0, spl_pkg::SPD_1000, 5'h1F);
    bus(spl_pkg::ADDR_CTRL, 1'b1, 32'h19);
    peer(1'b1, 1'b1, spl_pkg::SPD_1000, 5'h1F);
    check({local_ability, link_speed, link_full}, {5'h10, spl_pkg::SPD_1000, 1'b1});
    peer(1'b0, 1'b0, spl_pkg::SPD_10, 5'h1F);
    bus(spl_pkg::ADDR_CTRL, 1'b1, 32'h13);
    peer(1'b1, 1'b0, spl_pkg::SPD_10, 5'h1F);
    check({link_speed, link_full}, {spl_pkg::SPD_10, 1'b0});
    peer(1'b0, 1'b0, spl_pkg::SPD_10, 5'h1F);
    bus(spl_pkg::ADDR_CTRL, 1'b1, 32'h18);
    peer(1'b1, 1'b1, spl_pkg::SPD_100, 5'h1F);
    check({local_ability, link_speed, link_full}, {5'h04, spl_pkg::SPD_100, 1'b0});
  endtask

  task automatic t_shut_loop;
    bus(spl_pkg::ADDR_CTRL, 1'b1, 32'h50);
    wait_link(1'b0);
    check(local_ability, 5'h0);
    bus(spl_pkg::ADDR_CTRL, 1'b1, 32'h30);
    wait_link(1'b1);
    @(posedge hclk);
    mac_tx_req <= 1'b1; mac_txd <= 8'hC3;
    repeat (3) @(negedge hclk);
    check({mac_rx_dv, phy_tx_en, mac_rxd, phy_txd}, {2'h2, 8'hC3, 8'h00});
    @(posedge hclk);
    mac_tx_req <= 1'b0;
  endtask

  // Main sequence
  initial begin
    n_errors = 0; num_checks = 0; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
    hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; mac_tx_req = 1'b0; mac_txd = 8'h0;
    rx_buf_full = 1'b0; c_on = 1'b0; c_neg = 1'b0; c_busy = 1'b0; c_cross = 1'b0;
    c_spd = 2'h0; c_abil = 5'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_defaults;
    t_autoneg;
    t_full_flow;
    t_half;
    t_forced;
    t_shut_loop;
    complete_run;
  end
endmodule
